// [analog_comparator_control.sv]
// Control, status and interrupt logic around the on-chip voltage comparator
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/10ps
//Contract
//- comparator result is high when positive input exceeds negative input, else low.
//- raw result passes a synchroniser, one to two cycles, before readback.
//- writing one to bit 7 powers the comparator off, any time.
//- bit 6 one selects bandgap on positive input, zero selects the positive pin.
//- hardware sets flag bit 4 when an output event matches the mode.
//- flag clears automatically when the processor takes the vector.
//- writing one clears the flag, writing zero leaves it.
//- request only while flag, enable bit 3 and global enable are all set.
//- capture bit 2 one routes result to the timer capture trigger.
//- routed result uses the timer's noise canceller and edge select instead of pin.
//- mode bits 1:0: 00 toggle, 10 falling, 11 rising, 01 reserved.
//- mux enable one and converter off feeds the ADC mux to negative input.
//- in mux mode the channel field picks ADC pin 0 to 7.
module analog_comparator_control
  import comparator_pkg::*;
(
  input wire logic clk_sys, // System clock, 250 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [ADDR_W-1:0] regAddr, // Register address
  input wire logic [DATA_W-1:0] regWdata, // Register write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [DATA_W-1:0] regRdata_q, // Read data, cycle after strobe
  input wire logic cmpRaw, // Raw analog comparator output, asynchronous
  input wire logic adcOn, // Converter enabled, from ADC control A
  input wire logic [2:0] channelSelect, // Converter channel field
  input wire logic globalIrqEnable, // Processor global interrupt enable
  input wire logic irqVectorAck, // Pulse when comparator vector is taken
  output logic powerOff_q, // Comparator power switched off
  output logic bandgapSelect_q, // Bandgap drives positive input
  output logic negMuxSelect_q, // ADC mux drives negative input
  output logic [2:0] negChannel_q, // ADC pin feeding negative input
  output logic captureSelect_q, // Timer capture uses comparator, not pin
  output logic captureTrigger_q, // Comparator level into capture front end
  output logic irq_q // Comparator interrupt request, level
);

  typedef struct packed {
    logic powerOff;
    logic bandgap;
    logic flag;
    logic irqEn;
    logic capEn;
    logic [1:0] mode;
    logic negMuxEn;
    logic mask;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic capSel;
    logic capTrig;
    logic negSel;
    logic [2:0] negChan;
  } ctrl_state_t;

  ctrl_state_t q;
  ctrl_state_t d;
  cmp_event_if evIf ();

  logic wrCtrl;
  logic wrAdcB;
  logic wrStat;
  logic wrMask;
  logic flagClear;
  logic [DATA_W-1:0] ctrlView;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  cmp_sync_edge u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ifc(evIf)
  );

  // The analog core produces the comparison; we only sample it
  assign evIf.rawCmp = cmpRaw;
  assign evIf.modeSel = q.mode;

  always_comb begin
    ctrlView = '0;
    ctrlView[POWER_OFF_BIT] = q.powerOff;
    ctrlView[BANDGAP_BIT] = q.bandgap;
    ctrlView[RESULT_BIT] = evIf.level;
    ctrlView[FLAG_BIT] = q.flag;
    ctrlView[IRQ_EN_BIT] = q.irqEn;
    ctrlView[CAPTURE_BIT] = q.capEn;
    ctrlView[MODE_HI_BIT] = q.mode[1];
    ctrlView[MODE_LO_BIT] = q.mode[0];
  end

  assign wrCtrl = regWr & hit(regAddr, CTRL_STATUS_OFS);
  assign wrAdcB = regWr & hit(regAddr, ADC_CTRL_B_OFS);
  assign wrStat = regWr & hit(regAddr, IRQ_STATUS_OFS);
  assign wrMask = regWr & hit(regAddr, IRQ_MASK_OFS);

  // Either status view clears the same flag; the vector ack clears it too
  assign flagClear = (wrCtrl & regWdata[FLAG_BIT])
                   | (wrStat & regWdata[IRQ_EVENT_BIT])
                   | irqVectorAck;

  always_comb begin
    d = q;
    if (wrCtrl) begin
      d.powerOff = regWdata[POWER_OFF_BIT];
      d.bandgap = regWdata[BANDGAP_BIT];
      d.irqEn = regWdata[IRQ_EN_BIT];
      d.capEn = regWdata[CAPTURE_BIT];
      d.mode = regWdata[MODE_HI_BIT:MODE_LO_BIT];
    end
    if (wrAdcB) begin
      d.negMuxEn = regWdata[NEG_MUX_BIT];
    end
    if (wrMask) begin
      d.mask = regWdata[IRQ_EVENT_BIT];
    end
    // A new event in the clearing cycle wins over the clear
    d.flag = (q.flag & ~flagClear) | evIf.eventHit;

    d.rdata = '0;
    if (regRd) begin
      case (regAddr)
        CTRL_STATUS_OFS: d.rdata = ctrlView;
        ADC_CTRL_B_OFS: d.rdata = {1'b0, q.negMuxEn, 6'b00_0000};
        IRQ_STATUS_OFS: d.rdata = {7'b000_0000, q.flag};
        IRQ_MASK_OFS: d.rdata = {7'b000_0000, q.mask};
        default: d.rdata = '0;
      endcase
    end

    d.irq = q.flag & q.irqEn & globalIrqEnable & q.mask;
    d.capSel = q.capEn;
    // Gated to zero so a disabled route leaves the capture path untouched
    d.capTrig = q.capEn & evIf.level;
    d.negSel = q.negMuxEn & ~adcOn;
    d.negChan = channelSelect;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q <= '0;
      q.powerOff <= CTRL_STATUS_RST[POWER_OFF_BIT];
      q.bandgap <= CTRL_STATUS_RST[BANDGAP_BIT];
      q.flag <= CTRL_STATUS_RST[FLAG_BIT];
      q.irqEn <= CTRL_STATUS_RST[IRQ_EN_BIT];
      q.capEn <= CTRL_STATUS_RST[CAPTURE_BIT];
      q.mode <= CTRL_STATUS_RST[MODE_HI_BIT:MODE_LO_BIT];
      q.negMuxEn <= ADC_CTRL_B_RST[NEG_MUX_BIT];
      q.mask <= IRQ_MASK_RST[IRQ_EVENT_BIT];
    end else begin
      q <= d;
    end
  end

  assign regRdata_q = q.rdata;
  assign powerOff_q = q.powerOff;
  assign bandgapSelect_q = q.bandgap;
  assign negMuxSelect_q = q.negSel;
  assign negChannel_q = q.negChan;
  assign captureSelect_q = q.capSel;
  assign captureTrigger_q = q.capTrig;
  assign irq_q = q.irq;

endmodule

// [comparator_pkg.sv]
// Shared constants and types for the comparator control block
package comparator_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] CTRL_STATUS_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] ADC_CTRL_B_OFS = 4'h1;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 4'h3;

  // Field positions in comparator_control_status
  localparam int POWER_OFF_BIT = 7;
  localparam int BANDGAP_BIT = 6;
  localparam int RESULT_BIT = 5;
  localparam int FLAG_BIT = 4;
  localparam int IRQ_EN_BIT = 3;
  localparam int CAPTURE_BIT = 2;
  localparam int MODE_HI_BIT = 1;
  localparam int MODE_LO_BIT = 0;

  // Field position in adc_control_b
  localparam int NEG_MUX_BIT = 6;

  // Field position in the interrupt status and mask registers
  localparam int IRQ_EVENT_BIT = 0;

  // Values after reset
  localparam logic [DATA_W-1:0] CTRL_STATUS_RST = 8'h00;
  localparam logic [DATA_W-1:0] ADC_CTRL_B_RST = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_MASK_RST = 8'h01;

  // Flip-flops in the comparator synchroniser
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    MODE_TOGGLE = 2'b00,
    MODE_RESERVED = 2'b01,
    MODE_FALL = 2'b10,
    MODE_RISE = 2'b11
  } event_mode_t;

endpackage

// [cmp_event_if.sv]
// Interface between comparator control and its synchroniser / edge detector
`timescale 1ns/10ps
interface cmp_event_if;
  logic rawCmp;
  logic [1:0] modeSel;
  logic level;
  logic eventHit;

  modport sync (
    input rawCmp,
    input modeSel,
    output level,
    output eventHit
  );

  modport ctrl (
    output rawCmp,
    output modeSel,
    input level,
    input eventHit
  );
endinterface

// [cmp_sync_edge.sv]
// Synchroniser and event detector for the raw comparator output
`timescale 1ns/10ps
module cmp_sync_edge
  import comparator_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  cmp_event_if.sync ifc // Raw input, mode, synced level, event pulse
);

  typedef struct packed {
    logic meta;
    logic level;
    logic prev;
    logic hit;
    logic [2:0] warm;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  function automatic logic modeMatch(input logic [1:0] mode, input logic cur,
                                     input logic old);
    logic rise;
    logic fall;
    rise = cur & ~old;
    fall = ~cur & old;
    case (mode)
      MODE_TOGGLE: modeMatch = rise | fall;
      MODE_FALL: modeMatch = fall;
      MODE_RISE: modeMatch = rise;
      default: modeMatch = 1'b0;
    endcase
  endfunction

  always_comb begin
    d = q;
    d.meta = ifc.rawCmp;
    d.level = q.meta;
    d.prev = q.level;
    // Reserved mode never fires, so a stray code cannot raise the flag
    // Held off until level and prev both carry real samples, else a high input
    // at reset release would look like a rising edge
    d.warm = {q.warm[1:0], 1'b1};
    d.hit = q.warm[2] & modeMatch(ifc.modeSel, q.level, q.prev);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ifc.level = q.level;
  assign ifc.eventHit = q.hit;

endmodule

// [comparator_ctrl_sva.sv]
// Port assertions for the comparator control block
`timescale 1ns/10ps
module comparator_ctrl_sva
  import comparator_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [ADDR_W-1:0] regAddr, // Address
  input wire logic [DATA_W-1:0] regWdata, // Write data
  input wire logic regWr, // Write
  input wire logic regRd, // Read
  input wire logic [DATA_W-1:0] regRdata_q, // Read data
  input wire logic cmpRaw, // Raw result
  input wire logic adcOn, // Converter on
  input wire logic globalIrqEnable, // Global enable
  input wire logic irqVectorAck, // Vector taken
  input wire logic powerOff_q, // Power off
  input wire logic negMuxSelect_q, // Mux on
  input wire logic captureSelect_q, // Capture route
  input wire logic captureTrigger_q, // Capture level
  input wire logic irq_q // Request
);
  logic [4:0] hist_q;
  logic quiet;
  // Six equal samples: no edge can reach the flag in the next two cycles
  always_ff @(posedge clk_sys) begin
    hist_q <= {hist_q[3:0], cmpRaw};
  end
  assign quiet = ({hist_q, cmpRaw} == 6'h00) || ({hist_q, cmpRaw} == 6'h3f);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_RESULT: assert property (
    regRd && regAddr == CTRL_STATUS_OFS && !$past(sys_rst, 2)
    |=> regRdata_q[RESULT_BIT] == $past(cmpRaw, 3)) else $error("result bit wrong");
  AST_CAP_ON: assert property (captureSelect_q && $past(captureSelect_q)
    |-> captureTrigger_q == $past(cmpRaw, 3)) else $error("capture level wrong");
  AST_CAP_OFF: assert property (!captureSelect_q && !$past(captureSelect_q)
    |-> !captureTrigger_q) else $error("capture level while unrouted");
  AST_WR_CLR: assert property (
    regWr && regAddr == IRQ_STATUS_OFS && regWdata[IRQ_EVENT_BIT] && quiet
    |-> ##2 !irq_q) else $error("flag not cleared by write");
  AST_ACK_CLR: assert property (irqVectorAck && quiet |-> ##2 !irq_q)
    else $error("flag not cleared by vector");
  AST_IRQ_GATE: assert property (irq_q |-> $past(globalIrqEnable))
    else $error("request without global enable");
  AST_MUX_OFF: assert property ($past(adcOn) |-> !negMuxSelect_q)
    else $error("mux kept while converter on");
  AST_POWER: assert property (regWr && regAddr == CTRL_STATUS_OFS ##1 !regWr
    |=> powerOff_q == $past(regWdata[POWER_OFF_BIT], 2)) else $error("power bit wrong");
  cover property (irq_q);
  cover property ($rose(captureTrigger_q));
  cover property (irqVectorAck && quiet);
endmodule

// [cmp_core_model.sv]
// Behavioural analog comparator core and timer capture request on the far side
`timescale 1ns/10ps
module cmp_core_model #(
  parameter int BANDGAP_MV = 1100 // Reference level, plain default
) (
  input wire logic powerOff, // Core off
  input wire logic bandgapSel, // Bandgap on plus
  input wire logic muxSel, // ADC pin on minus
  input wire logic [2:0] channel, // ADC pin
  input int posMv, // Plus pin
  input int negMv, // Minus pin
  input int adcMv [8], // ADC pins
  input wire logic capSel, // Capture routed to comparator
  input wire logic capLevel, // Capture front-end level
  input wire logic capIrqEn, // Timer capture interrupt enable
  output logic cmpOut, // Result
  output logic capIrq // Timer capture request
);
  // Capture interrupt needs its own enable in the timer as well
  assign capIrq = capSel & capLevel & capIrqEn;
  int pos;
  int neg;
  always_comb begin
    pos = bandgapSel ? BANDGAP_MV : posMv;
    neg = muxSel ? adcMv[channel] : negMv;
    cmpOut = !powerOff && (pos > neg);
  end
endmodule

// [analog_comparator_control_tb_top.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
module analog_comparator_control_tb_top;
  import comparator_pkg::*;
  typedef struct {event_mode_t mode; logic up; logic [7:0] flag;} row_t;
  logic clk_sys = 0;
  logic sys_rst = 1;
  logic [ADDR_W-1:0] regAddr = 4'h0;
  logic [DATA_W-1:0] regWdata = 8'h00;
  logic regWr = 0, regRd = 0, cmpRaw, adcOn = 0, globalIrqEnable = 0, irqVectorAck = 0;
  logic [2:0] channelSelect = 3'h0, negChannel_q;
  logic [DATA_W-1:0] regRdata_q, rdv;
  logic powerOff_q, bandgapSelect_q, negMuxSelect_q, captureSelect_q, captureTrigger_q, irq_q;
  logic timerCaptureIrqEnable = 1;
  logic capIrq;
  int posMv = 500, negMv = 1000, n_mismatch = 0, checked = 0;
  int adcMv [8] = '{default: 0};
  row_t rows [7] = '{'{MODE_TOGGLE, 1, 8'h01}, '{MODE_TOGGLE, 0, 8'h01},
    '{MODE_FALL, 0, 8'h01}, '{MODE_FALL, 1, 8'h00}, '{MODE_RISE, 1, 8'h01},
    '{MODE_RISE, 0, 8'h00}, '{MODE_RESERVED, 1, 8'h00}};
  always #2 clk_sys = ~clk_sys;
  analog_comparator_control uut (.*);
  cmp_core_model core (.powerOff(powerOff_q), .bandgapSel(bandgapSelect_q),
    .muxSel(negMuxSelect_q), .channel(negChannel_q), .posMv, .negMv, .adcMv,
    .capSel(captureSelect_q), .capLevel(captureTrigger_q), .capIrqEn(timerCaptureIrqEnable),
    .cmpOut(cmpRaw), .capIrq(capIrq));
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1;
    @(posedge clk_sys);
    regWr <= 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1;
    @(posedge clk_sys);
    regRd <= 0;
    @(posedge clk_sys);
    d = regRdata_q;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    idle(20000);
    n_mismatch++;
    test_done();
  end
  initial begin
    idle(10);
    sys_rst <= 0;
    wr(4'h7, 8'hff);
    rd(CTRL_STATUS_OFS, rdv);
    chk("ctrl reset", rdv, CTRL_STATUS_RST);
    rd(IRQ_MASK_OFS, rdv);
    chk("mask reset", rdv, IRQ_MASK_RST);
    $display("reset test done");
    // Mode is changed with the interrupt off, then the stale flag is cleared
    foreach (rows[i]) begin
      posMv <= rows[i].up ? 500 : 1500;
      wr(CTRL_STATUS_OFS, {6'h00, rows[i].mode});
      idle(6);
      wr(IRQ_STATUS_OFS, 8'h01);
      posMv <= rows[i].up ? 1500 : 500;
      idle(6);
      rd(IRQ_STATUS_OFS, rdv);
      chk("event flag", rdv & 8'h01, rows[i].flag);
      $display("row %0d done", i);
    end
    wr(CTRL_STATUS_OFS, 8'h03);
    posMv <= 500;
    idle(6);
    wr(IRQ_STATUS_OFS, 8'h01);
    wr(CTRL_STATUS_OFS, 8'h0b);
    globalIrqEnable <= 1;
    posMv <= 1500;
    idle(8);
    wr(IRQ_STATUS_OFS, 8'h00);
    idle(2);
    chk("irq kept", {7'h00, irq_q}, 8'h01);
    wr(IRQ_MASK_OFS, 8'h00);
    idle(2);
    chk("irq masked", {7'h00, irq_q}, 8'h00);
    wr(IRQ_MASK_OFS, 8'h01);
    globalIrqEnable <= 0;
    idle(2);
    chk("irq global off", {7'h00, irq_q}, 8'h00);
    globalIrqEnable <= 1;
    wr(IRQ_STATUS_OFS, 8'h01);
    idle(2);
    chk("irq cleared", {7'h00, irq_q}, 8'h00);
    posMv <= 500;
    idle(4);
    posMv <= 1500;
    idle(8);
    chk("irq set", {7'h00, irq_q}, 8'h01);
    irqVectorAck <= 1;
    idle(1);
    irqVectorAck <= 0;
    idle(2);
    chk("irq acked", {7'h00, irq_q}, 8'h00);
    $display("irq test done");
    wr(CTRL_STATUS_OFS, 8'h00);
    posMv <= 500;
    wr(CTRL_STATUS_OFS, 8'h44);
    idle(4);
    rd(CTRL_STATUS_OFS, rdv);
    chk("bandgap result", rdv & 8'h20, 8'h20);
    chk("bandgap select", {7'h00, bandgapSelect_q}, 8'h01);
    chk("capture", {5'h00, capIrq, captureSelect_q, captureTrigger_q}, 8'h07);
    adcMv[5] <= 2000;
    channelSelect <= 3'h5;
    wr(ADC_CTRL_B_OFS, 8'h40);
    idle(6);
    chk("mux", {3'h0, negMuxSelect_q, negChannel_q, captureTrigger_q}, 8'h1a);
    adcOn <= 1;
    idle(6);
    chk("mux off", {7'h00, captureTrigger_q}, 8'h01);
    // Comparator held high across a reset must not look like a fresh edge
    posMv <= 1500;
    sys_rst <= 1;
    idle(2);
    sys_rst <= 0;
    idle(8);
    rd(IRQ_STATUS_OFS, rdv);
    chk("flag after reset", rdv, 8'h00);
    rd(CTRL_STATUS_OFS, rdv);
    chk("ctrl after reset", rdv, CTRL_STATUS_RST | 8'h20);
    $display("mid reset test done");
    wr(CTRL_STATUS_OFS, 8'h80);
    idle(2);
    chk("power off", {6'h00, powerOff_q, captureTrigger_q}, 8'h02);
    $display("analog test done");
    test_done();
  end
endmodule
bind analog_comparator_control comparator_ctrl_sva sva (.*);
